// [design/fti_pkg.sv]
`default_nettype none
package fti_pkg;
   // ------------------------------------------------------------
   // rounding mode encodings
   // ------------------------------------------------------------
   localparam logic [1:0] RM_NEAREST = 2'h0; // round to nearest even
   localparam logic [1:0] RM_PLUS = 2'h1; // toward plus infinity
   localparam logic [1:0] RM_MINUS = 2'h2; // toward minus infinity
   localparam logic [1:0] RM_ZERO = 2'h3; // toward zero

   // ------------------------------------------------------------
   // single precision thresholds, magnitude only
   // ------------------------------------------------------------
   localparam logic [30:0] SP_INF = 31'h7f800000;
   localparam logic [30:0] SP_2P32 = 31'h4f800000;
   localparam logic [30:0] SP_2P31 = 31'h4f000000;
   localparam logic [30:0] SP_2P30 = 31'h4e800000;
   localparam logic [7:0] SP_EXP_ONE = 8'h7f; // exponent of 1.0
   localparam logic [7:0] SP_EXP_HALF = 8'h7e; // exponent of 0.5

   // ------------------------------------------------------------
   // double precision thresholds, magnitude only
   // ------------------------------------------------------------
   localparam logic [62:0] DP_INF = 63'h7ff0000000000000;
   localparam logic [62:0] DP_2P32 = 63'h41f0000000000000;
   localparam logic [62:0] DP_U_NP = 63'h41efffffffe00000; // above: P
   localparam logic [62:0] DP_U_N = 63'h41efffffffefffff; // above: N
   localparam logic [62:0] DP_2P31 = 63'h41e0000000000000;
   localparam logic [62:0] DP_S_P = 63'h41dfffffffc00000; // above: P
   localparam logic [62:0] DP_S_N = 63'h41dfffffffdfffff; // above: N
   localparam logic [62:0] DP_2P30 = 63'h41d0000000000000;
   localparam logic [62:0] DP_NEG_HALF = 63'h41e0000000100000;
   localparam logic [62:0] DP_NEG_ONE = 63'h41e0000000200000;
   localparam logic [10:0] DP_EXP_ONE = 11'h3ff;
   localparam logic [10:0] DP_EXP_HALF = 11'h3fe;

   // ------------------------------------------------------------
   // stored results
   // ------------------------------------------------------------
   localparam logic [31:0] RES_ZERO = 32'h00000000;
   localparam logic [31:0] RES_U_MAX = 32'hffffffff;
   localparam logic [31:0] RES_S_MAX = 32'h7fffffff;
   localparam logic [31:0] RES_S_MIN = 32'h80000000;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      unsigned_int_to_float_op = 3'h0,
      signed_int_to_float_op = 3'h1,
      float_to_unsigned_op = 3'h2,
      float_to_unsigned_rz_op = 3'h3,
      float_to_signed_op = 3'h4,
      float_to_signed_rz_op = 3'h5
   } fti_op_t;

   // response class of one input range
   typedef enum logic [2:0] {
      resp_none = 3'h0,
      resp_all = 3'h1,
      resp_signed = 3'h2,
      resp_unsigned = 3'h3,
      signed_bounce_except_rz = 3'h4,
      unsigned_bounce_except_rz = 3'h5,
      resp_u_and_snz = 3'h6,
      resp_s_and_unz = 3'h7
   } fti_resp_t;

   typedef struct packed {
      logic valid; // conversion issued this cycle
      fti_op_t op;
      logic dp; // operand is double precision
      logic [1:0] rmode; // current rounding mode
      logic [63:0] operand; // single precision in [31:0]
   } fti_req_t;

   typedef struct packed {
      fti_resp_t resp;
      logic u_inv; // unsigned status invalid
      logic s_inv; // signed status invalid
      logic u_fix; // unsigned result fixed here
      logic s_fix; // signed result fixed here
      logic [31:0] u_res;
      logic [31:0] s_res;
   } fti_cls_t;

   typedef struct packed {
      logic valid; // answer to a request one cycle back
      logic bounce; // hand to support code
      logic invalid; // invalid operation status
      logic fixed; // result below replaces datapath value
      logic [31:0] result;
   } fti_rsp_t;

   // negative value whose integer rounds to zero
   function automatic logic fti_neg_to_zero(input logic is_zero,
         input logic below_half, input logic at_half,
         input logic below_one, input logic [1:0] rm);
      return is_zero | (below_one & ((rm == RM_ZERO) |
         (rm == RM_PLUS) |
         ((rm == RM_NEAREST) & (below_half | at_half))));
   endfunction : fti_neg_to_zero
endpackage : fti_pkg
`default_nettype wire

// [design/fti_sp_classify.sv]
`timescale 1ns/1ps
`default_nettype none
module fti_sp_classify (
   input wire logic [31:0] x,
   input wire logic [1:0] rm,
   output var fti_pkg::fti_cls_t cls
);
   // ------------------------------------------------------------
   // field split
   // ------------------------------------------------------------
   logic sgn; // sign of operand
   logic [30:0] mag; // magnitude bits
   logic to_zero; // negative that rounds to zero
   assign sgn = x[31];
   assign mag = x[30:0];
   assign to_zero = fti_pkg::fti_neg_to_zero(mag == 31'h0,
      x[30:23] < fti_pkg::SP_EXP_HALF,
      (x[30:23] == fti_pkg::SP_EXP_HALF) & (x[22:0] == 23'h0),
      x[30:23] < fti_pkg::SP_EXP_ONE, rm);

   // ------------------------------------------------------------
   // range decode, nan checked first
   // ------------------------------------------------------------
   always_comb begin
      cls = '0;
      cls.resp = fti_pkg::resp_none;
      if (mag > fti_pkg::SP_INF) begin
         cls.resp = fti_pkg::resp_all;
         cls.u_inv = 1'b1;
         cls.s_inv = 1'b1;
         cls.u_fix = 1'b1;
         cls.s_fix = 1'b1;
      end else if (!sgn) begin
         if (mag >= fti_pkg::SP_2P32) begin
            cls.resp = fti_pkg::resp_all;
            cls.u_inv = 1'b1;
            cls.s_inv = 1'b1;
            cls.u_fix = 1'b1;
            cls.s_fix = 1'b1;
            cls.u_res = fti_pkg::RES_U_MAX;
            cls.s_res = fti_pkg::RES_S_MAX;
         end else if (mag >= fti_pkg::SP_2P31) begin
            cls.resp = fti_pkg::resp_s_and_unz;
            cls.s_inv = 1'b1;
            cls.s_fix = 1'b1;
            cls.s_res = fti_pkg::RES_S_MAX;
         end else if (mag >= fti_pkg::SP_2P30) begin
            cls.resp = fti_pkg::signed_bounce_except_rz;
         end
         // below 2^30 stays resp_none, both valid
      end else begin
         // unsigned of a negative: zero, invalid unless it rounds to 0
         cls.u_fix = 1'b1;
         cls.u_inv = !to_zero;
         if (mag < fti_pkg::SP_2P31) begin
            cls.resp = fti_pkg::resp_unsigned;
         end else if (mag == fti_pkg::SP_2P31) begin
            cls.resp = fti_pkg::resp_u_and_snz;
            cls.s_fix = 1'b1;
            cls.s_res = fti_pkg::RES_S_MIN;
         end else begin
            cls.resp = fti_pkg::resp_all;
            cls.s_inv = 1'b1;
            cls.s_fix = 1'b1;
            cls.s_res = fti_pkg::RES_S_MIN;
         end
      end
   end
endmodule : fti_sp_classify
`default_nettype wire

// [design/fti_dp_classify.sv]
`timescale 1ns/1ps
`default_nettype none
module fti_dp_classify (
   input wire logic [63:0] x,
   input wire logic [1:0] rm,
   output var fti_pkg::fti_cls_t cls
);
   // ------------------------------------------------------------
   // field split
   // ------------------------------------------------------------
   logic sgn; // sign of operand
   logic [62:0] mag; // magnitude bits
   logic to_zero; // negative that rounds to zero
   logic np; // nearest or plus mode
   assign sgn = x[63];
   assign mag = x[62:0];
   assign np = (rm == fti_pkg::RM_NEAREST) | (rm == fti_pkg::RM_PLUS);
   assign to_zero = fti_pkg::fti_neg_to_zero(mag == 63'h0,
      x[62:52] < fti_pkg::DP_EXP_HALF,
      (x[62:52] == fti_pkg::DP_EXP_HALF) & (x[51:0] == 52'h0),
      x[62:52] < fti_pkg::DP_EXP_ONE, rm);

   // ------------------------------------------------------------
   // range decode; the mode-dependent status follows the rounding
   // carry into the next integer at each band's top
   // ------------------------------------------------------------
   always_comb begin
      cls = '0;
      cls.resp = fti_pkg::resp_none;
      if (mag > fti_pkg::DP_INF ||
            (sgn && mag == fti_pkg::DP_INF)) begin
         cls.resp = fti_pkg::resp_all;
         cls.u_inv = 1'b1;
         cls.s_inv = 1'b1;
         cls.u_fix = 1'b1;
         cls.s_fix = 1'b1;
      end else if (!sgn) begin
         if (mag >= fti_pkg::DP_2P32) begin
            cls.resp = fti_pkg::resp_all;
            cls.u_inv = 1'b1;
            cls.s_inv = 1'b1;
            cls.u_fix = 1'b1;
            cls.s_fix = 1'b1;
            cls.u_res = fti_pkg::RES_U_MAX;
            cls.s_res = fti_pkg::RES_S_MAX;
         end else if (mag >= fti_pkg::DP_2P31) begin
            cls.resp = fti_pkg::resp_s_and_unz;
            cls.s_inv = 1'b1;
            cls.s_fix = 1'b1;
            cls.s_res = fti_pkg::RES_S_MAX;
            cls.u_inv = (mag > fti_pkg::DP_U_N && np) ||
               (mag > fti_pkg::DP_U_NP && rm == fti_pkg::RM_PLUS);
            cls.u_fix = cls.u_inv;
            cls.u_res = cls.u_inv ? fti_pkg::RES_U_MAX : fti_pkg::RES_ZERO;
         end else if (mag >= fti_pkg::DP_2P30) begin
            cls.resp = fti_pkg::signed_bounce_except_rz;
            cls.s_inv = (mag > fti_pkg::DP_S_N && np) ||
               (mag > fti_pkg::DP_S_P && rm == fti_pkg::RM_PLUS);
            cls.s_fix = cls.s_inv;
            cls.s_res = cls.s_inv ? fti_pkg::RES_S_MAX : fti_pkg::RES_ZERO;
         end
         // below 2^30 stays resp_none
      end else begin
         cls.u_fix = 1'b1;
         cls.u_inv = !to_zero;
         if (mag < fti_pkg::DP_2P31) begin
            cls.resp = fti_pkg::resp_unsigned;
         end else if (mag < fti_pkg::DP_NEG_ONE) begin
            cls.resp = fti_pkg::resp_u_and_snz;
            cls.s_fix = 1'b1;
            cls.s_res = fti_pkg::RES_S_MIN;
            cls.s_inv = (mag != fti_pkg::DP_2P31) &&
               ((rm == fti_pkg::RM_MINUS) ||
               (mag > fti_pkg::DP_NEG_HALF && rm == fti_pkg::RM_NEAREST));
         end else begin
            cls.resp = fti_pkg::resp_all;
            cls.s_inv = 1'b1;
            cls.s_fix = 1'b1;
            cls.s_res = fti_pkg::RES_S_MIN;
         end
      end
   end
endmodule : fti_dp_classify
`default_nettype wire

// [design/fti_bounce_detect.sv]
// Overview of operation
// - integer to float never bounces
// - out of range reports invalid only
// - thresholds depend on rounding mode
// - response class picks which conversions bounce
// - single nan bounces, zero, invalid
// - single from infinity to 2^32 bounces, saturates
// - single 2^31 band: signed saturates invalid
// - single 2^30 band valid, signed bounce except rz
// - single below 2^30 never bounces
// - single small negatives bounce unsigned only
// - single minus 2^31 signed valid 0x80000000
// - single below minus 2^31 always bounces
// - negative rounding to zero is not invalid
// - double nan, minus infinity bounce, zero
// - double from infinity to 2^32 bounces
// - double 2^31 band, unsigned status by mode
// - double 2^30 band, signed status by mode
// - double below 2^30 never bounces
// - double small negatives bounce unsigned only
// - double near minus 2^31, signed status by mode
// - double far negatives always bounce
// - bounce marks only a potential exception
`timescale 1ns/1ps
`default_nettype none
module fti_bounce_detect (
   input wire logic clk,
   input wire logic rst_n,
   input wire fti_pkg::fti_req_t req,
   output var fti_pkg::fti_rsp_t rsp
);
   // ------------------------------------------------------------
   // operation decode
   // ------------------------------------------------------------
   logic is_itof; // integer to float conversion
   logic is_fti; // float to integer conversion
   logic is_sgn; // signed integer side
   logic force_rz; // op itself rounds toward zero
   logic [1:0] eff_rm; // rounding mode the conversion uses
   logic rz; // effective mode is round toward zero

   // which family and which flavour the request belongs to
   always_comb begin
      is_itof = 1'b0;
      is_fti = 1'b0;
      is_sgn = 1'b0;
      force_rz = 1'b0;
      case (req.op)
         fti_pkg::unsigned_int_to_float_op: begin
            is_itof = 1'b1;
         end
         fti_pkg::signed_int_to_float_op: begin
            is_itof = 1'b1;
            is_sgn = 1'b1;
         end
         fti_pkg::float_to_unsigned_op: begin
            is_fti = 1'b1;
         end
         fti_pkg::float_to_unsigned_rz_op: begin
            is_fti = 1'b1;
            force_rz = 1'b1;
         end
         fti_pkg::float_to_signed_op: begin
            is_fti = 1'b1;
            is_sgn = 1'b1;
         end
         fti_pkg::float_to_signed_rz_op: begin
            is_fti = 1'b1;
            is_sgn = 1'b1;
            force_rz = 1'b1;
         end
         default: begin
            // unused codes are treated as no conversion at all
            is_fti = 1'b0;
         end
      endcase
   end

   // the rz flavours ignore the mode register; the thresholds
   // below are chosen per mode so signed rz runs widest
   assign eff_rm = force_rz ? fti_pkg::RM_ZERO : req.rmode;
   assign rz = (eff_rm == fti_pkg::RM_ZERO);

   // ------------------------------------------------------------
   // range classifiers, one per precision
   // ------------------------------------------------------------
   fti_pkg::fti_cls_t sp_cls; // single precision verdict
   fti_pkg::fti_cls_t dp_cls; // double precision verdict
   fti_pkg::fti_cls_t cls; // verdict for this request

   // single precision operand sits in the low word
   fti_sp_classify u_sp (
      .x(req.operand[31:0]),
      .rm(eff_rm),
      .cls(sp_cls)
   );

   fti_dp_classify u_dp (
      .x(req.operand),
      .rm(eff_rm),
      .cls(dp_cls)
   );

   assign cls = req.dp ? dp_cls : sp_cls;

   // ------------------------------------------------------------
   // response class to bounce decision
   // ------------------------------------------------------------
   logic cls_bounce; // bounce implied by the class

   // pessimistic: a bounce is only a potential exception, the
   // support code settles the true status afterwards
   always_comb begin
      case (cls.resp)
         fti_pkg::resp_all: cls_bounce = 1'b1;
         fti_pkg::resp_signed: cls_bounce = is_sgn;
         fti_pkg::resp_unsigned: cls_bounce = !is_sgn;
         fti_pkg::signed_bounce_except_rz: begin
            cls_bounce = is_sgn && !rz;
         end
         fti_pkg::unsigned_bounce_except_rz: begin
            cls_bounce = !is_sgn && !rz;
         end
         fti_pkg::resp_u_and_snz: begin
            cls_bounce = !is_sgn || !rz;
         end
         fti_pkg::resp_s_and_unz: begin
            cls_bounce = is_sgn || !rz;
         end
         default: cls_bounce = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // next response, all combinational from the request
   // ------------------------------------------------------------
   fti_pkg::fti_rsp_t next_rsp; // answer formed in the issue cycle

   // decided in the issue cycle so the flag lands well before the
   // conversion result can commit
   always_comb begin
      next_rsp = '0;
      next_rsp.valid = req.valid;
      if (req.valid && is_fti) begin
         next_rsp.bounce = cls_bounce;
         // only invalid status exists here, no overflow path
         next_rsp.invalid = is_sgn ? cls.s_inv : cls.u_inv;
         next_rsp.fixed = is_sgn ? cls.s_fix : cls.u_fix;
         next_rsp.result = is_sgn ? cls.s_res : cls.u_res;
      end
      // integer to float leaves every flag low
   end

   // ------------------------------------------------------------
   // output register
   // ------------------------------------------------------------
   // one flop stage keeps the outputs glitch free; costs one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

   // ------------------------------------------------------------
   // checking helpers
   // ------------------------------------------------------------
   fti_pkg::fti_req_t p; // request answered by rsp
   logic p_sgn; // signed flavour of that request
   logic p_rz; // that request ran round toward zero
   logic p_fti; // that request was float to integer
   logic [31:0] p_sx; // its single precision word
   logic [62:0] p_dm; // its double precision magnitude

   // copy of the request one cycle back, read only by checks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         p <= '0;
         p_sgn <= 1'b0;
         p_rz <= 1'b0;
         p_fti <= 1'b0;
      end else begin
         p <= req;
         p_sgn <= is_sgn;
         p_rz <= rz;
         p_fti <= is_fti;
      end
   end

   assign p_sx = p.operand[31:0];
   assign p_dm = p.operand[62:0];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_itof_no_bounce: assert property (
      (rsp.valid && !p_fti) |-> !rsp.bounce && !rsp.invalid)
      else $error("integer to float raised a bounce");

   a_invalid_only_fti: assert property (
      rsp.invalid |-> rsp.valid && p_fti && rsp.fixed)
      else $error("invalid status without float to integer");

   a_rsp_follows_req: assert property (
      req.valid |=> rsp.valid)
      else $error("answer missing one cycle after request");

   a_sp_nan_zero: assert property (
      (rsp.valid && p_fti && !p.dp && p_sx[30:0] > 31'h7f800000)
      |-> rsp.bounce && rsp.invalid && rsp.result == 32'h00000000)
      else $error("single nan not bounced with zero");

   a_sp_high_sat: assert property (
      (rsp.valid && p_fti && !p.dp && !p_sx[31] &&
      p_sx >= 32'h4f800000 && p_sx <= 32'h7f800000)
      |-> rsp.bounce && rsp.invalid &&
      rsp.result == (p_sgn ? 32'h7fffffff : 32'hffffffff))
      else $error("single large positive not saturated");

   a_sp_snz_band: assert property (
      (rsp.valid && p_fti && !p.dp &&
      p_sx >= 32'h4e800000 && p_sx <= 32'h4effffff)
      |-> !rsp.invalid && (rsp.bounce == (p_sgn && !p_rz)))
      else $error("single 2^30 band bounce wrong");

   a_sp_small_pass: assert property (
      (rsp.valid && p_fti && !p.dp && p_sx <= 32'h4e7fffff)
      |-> !rsp.bounce && !rsp.invalid)
      else $error("single small positive bounced");

   a_sp_min_signed: assert property (
      (rsp.valid && p_fti && p_sgn && !p.dp && p_sx == 32'hcf000000)
      |-> !rsp.invalid && rsp.result == 32'h80000000 &&
      rsp.bounce == !p_rz)
      else $error("single minus 2^31 signed wrong");

   a_sp_neg_far: assert property (
      (rsp.valid && p_fti && !p.dp && p_sx > 32'hcf000000 &&
      p_sx <= 32'hff800000) |-> rsp.bounce && rsp.invalid)
      else $error("single far negative not bounced");

   a_neg_zero_ok: assert property (
      (rsp.valid && p_fti && !p_sgn && !p.dp &&
      p_sx == 32'h80000000) |-> rsp.bounce && !rsp.invalid)
      else $error("minus zero unsigned flagged invalid");

   a_dp_neg_inf: assert property (
      (rsp.valid && p_fti && p.dp &&
      p.operand == 64'hfff0000000000000)
      |-> rsp.bounce && rsp.invalid && rsp.result == 32'h00000000)
      else $error("double minus infinity not zero");

   a_dp_high_bounce: assert property (
      (rsp.valid && p_fti && p.dp && !p.operand[63] &&
      p.operand[62:0] >= 63'h41f0000000000000 &&
      p.operand[62:0] <= 63'h7ff0000000000000)
      |-> rsp.bounce && rsp.invalid)
      else $error("double large positive not bounced");

   a_class_gate: assert property (
      (rsp.valid && p_fti && p.dp && !p.operand[63] &&
      p.operand[62:0] < 63'h41d0000000000000) |-> !rsp.bounce)
      else $error("double below 2^30 bounced");

   a_sp_top_band: assert property (
      (rsp.valid && p_fti && !p.dp &&
      p_sx >= 32'h4f000000 && p_sx <= 32'h4f7fffff)
      |-> rsp.bounce == (p_sgn || !p_rz) &&
      rsp.invalid == p_sgn)
      else $error("single 2^31 band wrong");

   a_sp_neg_near: assert property (
      (rsp.valid && p_fti && !p.dp &&
      p_sx >= 32'h80000000 && p_sx <= 32'hceffffff)
      |-> rsp.bounce == !p_sgn && !(p_sgn && rsp.invalid))
      else $error("single small negative bounce wrong");

   a_dp_top_band: assert property (
      (rsp.valid && p_fti && p.dp && !p.operand[63] &&
      p_dm >= 63'h41e0000000000000 && p_dm < 63'h41f0000000000000)
      |-> rsp.bounce == (p_sgn || !p_rz) &&
      (rsp.invalid || !p_sgn))
      else $error("double 2^31 band wrong");

   a_dp_snz_band: assert property (
      (rsp.valid && p_fti && p.dp && !p.operand[63] &&
      p_dm >= 63'h41d0000000000000 && p_dm < 63'h41e0000000000000)
      |-> rsp.bounce == (p_sgn && !p_rz) &&
      !(rsp.invalid && (!p_sgn || p_rz)))
      else $error("double 2^30 band wrong");

   a_dp_near_min: assert property (
      (rsp.valid && p_fti && p.dp && p.operand[63] &&
      p_dm >= 63'h41e0000000000000 && p_dm < 63'h41e0000000200000)
      |-> rsp.bounce == (!p_sgn || !p_rz) && (rsp.invalid || p_sgn) &&
      rsp.result == (p_sgn ? 32'h80000000 : 32'h0))
      else $error("double near minus 2^31 wrong");

   a_dp_neg_far: assert property (
      (rsp.valid && p_fti && p.dp && p.operand[63] &&
      p_dm >= 63'h41e0000000200000 && p_dm < 63'h7ff0000000000000)
      |-> rsp.bounce && rsp.invalid &&
      rsp.result == (p_sgn ? 32'h80000000 : 32'h0))
      else $error("double far negative not bounced");

   // ------------------------------------------------------------
   // coverage of main scenarios
   // ------------------------------------------------------------
   c_sp_bounce: cover property (rsp.valid && rsp.bounce && !p.dp);
   c_dp_bounce: cover property (rsp.valid && rsp.bounce && p.dp);
   c_signed_rz_pass: cover property (
      rsp.valid && p_sgn && p_rz && !rsp.bounce &&
      p_sx >= 32'h4e800000 && !p.dp);
   c_neg_to_zero: cover property (
      rsp.valid && rsp.bounce && !p_sgn && !rsp.invalid && rsp.fixed);
   c_rz_op_mode: cover property (rsp.valid && p_rz && p.rmode != 2'h3);
endmodule : fti_bounce_detect
`default_nettype wire

// [sim/fti_bounce_detect_test.sv]
`timescale 1ns/1ps
`default_nettype none
module fti_bounce_detect_test;
   // ---------------------------------------------
   // vectors, bounce class 0 never 1 always 2 not rz
   // ---------------------------------------------
   typedef struct packed {
      logic [63:0] x;
      logic dp; // double operand
      logic z; // stored results are zero
      logic [1:0] uc;
      logic [1:0] sc;
      logic ui;
      logic si;
   } fti_vec_t;
   // status invalid only in the modes set in mask
   typedef struct packed {
      logic [63:0] x;
      logic dp;
      logic s;
      logic [3:0] mask;
      logic [31:0] res;
   } fti_mvec_t;
   logic clk;
   logic rst_n;
   fti_pkg::fti_req_t req;
   fti_pkg::fti_rsp_t rsp;
   int errors;
   int checks;
   fti_vec_t vecs [0:19];
   fti_mvec_t mvecs [0:3];
   fti_bounce_detect dut_u (
      .clk(clk),
      .rst_n(rst_n),
      .req(req),
      .rsp(rsp)
   );
   // 10 ns clock
   always #5 clk = ~clk;
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp
   // mode 3 uses the rz opcodes, the rest the plain ones
   function automatic fti_pkg::fti_op_t op_of(input logic s, input int m);
      if (s) begin
         return m == 3 ? fti_pkg::float_to_signed_rz_op
            : fti_pkg::float_to_signed_op;
      end
      return m == 3 ? fti_pkg::float_to_unsigned_rz_op
         : fti_pkg::float_to_unsigned_op;
   endfunction : op_of
   // saturated value stored for an invalid conversion
   function automatic logic [31:0] sat(input logic z, input logic s,
         input logic neg);
      if (z) return 32'h0;
      if (s) return neg ? 32'h80000000 : 32'h7fffffff;
      return neg ? 32'h0 : 32'hffffffff;
   endfunction : sat
   // one request, answer judged 1 ns after the taking edge
   task automatic run(input fti_pkg::fti_op_t op, input logic [1:0] rm,
         input logic [63:0] x, input logic dp, input logic b,
         input logic inv, input logic [31:0] res);
      @(posedge clk);
      req <= '{1'h1, op, dp, rm, x};
      @(posedge clk);
      #1;
      cmp(rsp.valid, 1'h1);
      cmp(rsp.bounce, b);
      cmp(rsp.invalid, inv);
      if (inv) begin
         cmp(rsp.fixed, 1'h1);
         cmp(rsp.result, res);
      end
   endtask : run
   task automatic t_int();
      for (int m = 0; m < 4; m++) begin
         run(fti_pkg::unsigned_int_to_float_op, m[1:0],
            64'h7ff8000000000000, 1'h1, 1'h0, 1'h0, 32'h0);
         run(fti_pkg::signed_int_to_float_op, m[1:0],
            64'hff800000, 1'h0, 1'h0, 1'h0, 32'h0);
         cmp(rsp.fixed, 1'h0);
      end
      $display("int to float done");
   endtask : t_int
   task automatic t_table();
      logic neg;
      logic [1:0] c;
      for (int i = 0; i < 20; i++) begin
         neg = vecs[i].dp ? vecs[i].x[63] : vecs[i].x[31];
         for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
               c = s[0] ? vecs[i].sc : vecs[i].uc;
               // rz opcodes see a nearest mode register and ignore it
               run(op_of(s[0], m), m == 3 ? 2'h0 : m[1:0], vecs[i].x,
                  vecs[i].dp, c == 2'h1 || (c == 2'h2 && m != 3),
                  s[0] ? vecs[i].si : vecs[i].ui,
                  sat(vecs[i].z, s[0], neg));
            end
         end
      end
      $display("range table done");
   endtask : t_table
   // negative unsigned always bounces, the rest not in rz
   // plain opcodes here, rz comes from the mode register
   task automatic t_mode();
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 4; m++) begin
            run(op_of(mvecs[i].s, m & 2), m[1:0], mvecs[i].x, mvecs[i].dp,
               m != 3 || (!mvecs[i].s && i == 3), mvecs[i].mask[m],
               mvecs[i].res);
         end
      end
      $display("mode dependent done");
   endtask : t_mode
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   // watchdog, tests need well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
   initial begin
      vecs = '{
         '{64'h7fc00000, 1'h0, 1'h1, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'h7f800000, 1'h0, 1'h0, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'h4f800000, 1'h0, 1'h0, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'h4f000000, 1'h0, 1'h0, 2'h2, 2'h1, 1'h0, 1'h1},
         '{64'h4e800000, 1'h0, 1'h0, 2'h0, 2'h2, 1'h0, 1'h0},
         '{64'h4e7fffff, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0},
         '{64'h80000000, 1'h0, 1'h0, 2'h1, 2'h0, 1'h0, 1'h0},
         '{64'hceffffff, 1'h0, 1'h0, 2'h1, 2'h0, 1'h1, 1'h0},
         '{64'hcf000000, 1'h0, 1'h0, 2'h1, 2'h2, 1'h1, 1'h0},
         '{64'hcf000001, 1'h0, 1'h0, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'hff800000, 1'h0, 1'h0, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'h7ff8000000000000, 1'h1, 1'h1, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'hfff0000000000000, 1'h1, 1'h1, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'h41f0000000000000, 1'h1, 1'h0, 2'h1, 2'h1, 1'h1, 1'h1},
         '{64'h41e0000000000000, 1'h1, 1'h0, 2'h2, 2'h1, 1'h0, 1'h1},
         '{64'h41d0000000000000, 1'h1, 1'h0, 2'h0, 2'h2, 1'h0, 1'h0},
         '{64'h41cfffffffffffff, 1'h1, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0},
         '{64'hc1d0000000000000, 1'h1, 1'h0, 2'h1, 2'h0, 1'h1, 1'h0},
         '{64'hc1e0000000000000, 1'h1, 1'h0, 2'h1, 2'h2, 1'h1, 1'h0},
         '{64'hc1e0000000200000, 1'h1, 1'h0, 2'h1, 2'h1, 1'h1, 1'h1}
      };
      mvecs = '{
         '{64'h41efffffffffffff, 1'h1, 1'h0, 4'h3, 32'hffffffff},
         '{64'h41dfffffffffffff, 1'h1, 1'h1, 4'h3, 32'h7fffffff},
         '{64'hc1e0000000100001, 1'h1, 1'h1, 4'h5, 32'h80000000},
         '{64'hbf400000, 1'h0, 1'h0, 4'h5, 32'h0}
      };
      clk = 1'h0;
      rst_n = 1'h0;
      errors = 0;
      checks = 0;
      // a request held during reset must leave no answer
      req = '{1'h1, fti_pkg::float_to_signed_op, 1'h0, 2'h0, 64'h7f800000};
      repeat (19) @(posedge clk);
      // no request may meet the releasing edge
      req <= '0;
      @(posedge clk);
      cmp(rsp, 36'h0);
      rst_n <= 1'h1;
      @(posedge clk);
      @(posedge clk);
      #1;
      cmp(rsp.valid, 1'h0);
      $display("reset done");
      t_int();
      t_table();
      t_mode();
      conclude();
   end
endmodule : fti_bounce_detect_test
`default_nettype wire
